//--- core/umcs_top.sv
// umcs_top.sv: modem control and status for one serial channel, apb slave
// assumes: apb master on clk, modem pins asynchronous, serial engines outside
// Operation
// - control bit 7 selects divide-by-four prescaler
// - control bit 6 opens threshold register access
// - control bit 5 enables resume on any character
// - bits 7..5 writable only with write enable
// - bit 4 loops control to status; transmit reaches rx_loop_data in every mode
// - loopback maps bits 3,2,0,1 to 7..4
// - bit 3 drives interrupts, general output low outside loopback
// - bit 2 enables ready summary register
// - bit 1 drives rts outside loopback unless auto rts
// - bit 0 drives dtr outside loopback
// - status 7..4 are inverted modem pins
// - carrier change sets status bit 3
// - ring rising edge sets status bit 2
// - dsr change sets status bit 1
// - cts change sets status bit 0
// - pins active low, register bits active high
// - change bits interrupt only when enabled
`timescale 1ns/1ps
`include "umcs_map.svh"
module umcs_top
	import umcs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cd_n,
	input wire logic ri_n,
	input wire logic dsr_n,
	input wire logic cts_n,
	input wire logic tx_serial,
	input wire logic auto_rts_level_n,
	input wire logic chan_irq_a,
	input wire logic chan_irq_b,
	output logic rts_n,
	output logic dtr_n,
	output logic general_output_pin,
	output logic interrupt_out_a,
	output logic interrupt_out_a_oe,
	output logic interrupt_out_b,
	output logic interrupt_out_b_oe,
	output logic rx_loop_data,
	output logic loop_active,
	output logic prescale_div4,
	output logic threshold_access,
	output logic xon_any_en,
	output logic ready_summary_en,
	output logic modem_irq,
	output logic irq
);
	// ==========================================
	// state
	typedef struct packed
	{
		umcs_byte_t ctrl;
		umcs_byte_t cfg;
		umcs_nib_t irq_stat;
		umcs_nib_t irq_en;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic rts_n;
		logic dtr_n;
		logic gop;
		logic ia;
		logic ia_oe;
		logic ib;
		logic ib_oe;
		logic rxl;
		logic loop;
		logic pre;
		logic thr;
		logic xany;
		logic rdy;
		logic mirq;
		logic irq;
	} umcs_state_t;

	umcs_state_t st_reg;
	umcs_state_t st_next;

	logic [3:0] pins_sync;
	logic [3:0] pins_hi;
	logic [3:0] cur;
	logic [3:0] delta;
	logic [3:0] evt;
	logic stat_rd;
	logic acc;
	logic wr;
	umcs_byte_t wb;
	umcs_byte_t stat_val;

	// ==========================================
	// pins: order cd, ri, dsr, cts; idle high means inactive
	umcs_sync #(.WIDTH(4), .INIT(4'hF)) u_sync
	(
		.clk(clk),
		.rstn(rstn),
		.din({cd_n, ri_n, dsr_n, cts_n}),
		.dout(pins_sync)
	);

	assign pins_hi = ~pins_sync;

	// loopback source: cd<-bit3, ri<-bit2, dsr<-bit0, cts<-bit1
	always_comb
	begin
		if (st_reg.ctrl[`UMCS_CTRL_LOOP])
			cur = {st_reg.ctrl[3], st_reg.ctrl[2], st_reg.ctrl[0], st_reg.ctrl[1]};
		else
			cur = pins_hi;
	end

	assign acc = psel & penable & st_reg.ready;
	assign wr = acc & pwrite & pstrb[0];
	assign wb = pwdata[7:0];
	assign stat_rd = psel & penable & ~pwrite & ~st_reg.ready & (paddr == `UMCS_OFF_STAT);

	umcs_delta u_delta
	(
		.clk(clk),
		.rstn(rstn),
		.cur(cur),
		.rd_clr(stat_rd),
		.delta(delta),
		.evt(evt)
	);

	assign stat_val = {cur, delta};

	// ==========================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		// one wait state: ready rises the cycle after penable
		st_next.ready = psel & penable & ~st_reg.ready;
		st_next.err = 1'b0;
		if (psel & penable & ~st_reg.ready)
		begin
			st_next.rdata = 32'h0000_0000;
			case (paddr)
				`UMCS_OFF_CTRL: st_next.rdata[7:0] = st_reg.ctrl;
				`UMCS_OFF_STAT: st_next.rdata[7:0] = stat_val;
				`UMCS_OFF_CFG: st_next.rdata[7:0] = st_reg.cfg;
				`UMCS_OFF_IRQ_STAT: st_next.rdata[3:0] = st_reg.irq_stat;
				`UMCS_OFF_IRQ_CLR: st_next.rdata = 32'h0000_0000;
				`UMCS_OFF_IRQ_EN: st_next.rdata[3:0] = st_reg.irq_en;
				default: st_next.err = 1'b1;
			endcase
		end
		if (wr)
		begin
			case (paddr)
				`UMCS_OFF_CTRL:
				begin
					st_next.ctrl[4:0] = wb[4:0];
					if (st_reg.cfg[`UMCS_CFG_EWE])
						st_next.ctrl[7:5] = wb[7:5];
				end
				`UMCS_OFF_CFG: st_next.cfg = {5'h00, wb[2:0]};
				`UMCS_OFF_IRQ_CLR: st_next.irq_stat = st_reg.irq_stat & ~wb[3:0];
				`UMCS_OFF_IRQ_EN: st_next.irq_en = wb[3:0];
				default: st_next.ctrl = st_next.ctrl;
			endcase
		end
		// sticky events win over clear
		st_next.irq_stat = st_next.irq_stat | evt;
		st_next.rdata = acc ? 32'h0000_0000 : st_next.rdata;
		st_next.rdata = st_next.ready ? st_next.rdata : 32'h0000_0000;

		// outputs from the control byte; rx loop data from tx_serial
		st_next.pre = st_next.ctrl[`UMCS_CTRL_PRE];
		st_next.thr = st_next.ctrl[`UMCS_CTRL_THR];
		st_next.xany = st_next.ctrl[`UMCS_CTRL_XANY];
		st_next.loop = st_next.ctrl[`UMCS_CTRL_LOOP];
		st_next.rdy = st_next.ctrl[`UMCS_CTRL_RDY];
		st_next.rxl = tx_serial;
		// loopback keeps rts, dtr and general output inactive; interrupt outputs still follow bit 3
		if (st_next.ctrl[`UMCS_CTRL_LOOP])
		begin
			st_next.rts_n = 1'b1;
			st_next.dtr_n = 1'b1;
			st_next.gop = 1'b1;
		end
		else
		begin
			if (st_next.cfg[`UMCS_CFG_ARTS])
				st_next.rts_n = auto_rts_level_n;
			else
				st_next.rts_n = ~st_next.ctrl[`UMCS_CTRL_RTS];
			st_next.dtr_n = ~st_next.ctrl[`UMCS_CTRL_DTR];
			st_next.gop = ~st_next.ctrl[`UMCS_CTRL_IRQOP];
		end
		st_next.ia_oe = st_next.ctrl[`UMCS_CTRL_IRQOP];
		st_next.ib_oe = st_next.ctrl[`UMCS_CTRL_IRQOP];
		st_next.ia = st_next.ctrl[`UMCS_CTRL_IRQOP] & chan_irq_a;
		st_next.ib = st_next.ctrl[`UMCS_CTRL_IRQOP] & chan_irq_b;
		// modem interrupt follows the flags, cleared by the status read
		st_next.mirq = st_next.cfg[`UMCS_CFG_MIE] & ((stat_rd ? 4'h0 : delta) != 4'h0 | evt != 4'h0);
		st_next.irq = (st_next.irq_stat & st_next.irq_en) != 4'h0;
	end

	// ==========================================
	// registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
			st_reg.ctrl <= `UMCS_CTRL_RST;
			st_reg.cfg <= `UMCS_CFG_RST;
			st_reg.irq_en <= 4'h0;
			st_reg.rts_n <= 1'b1;
			st_reg.dtr_n <= 1'b1;
			st_reg.gop <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.err;
	assign rts_n = st_reg.rts_n;
	assign dtr_n = st_reg.dtr_n;
	assign general_output_pin = st_reg.gop;
	assign interrupt_out_a = st_reg.ia;
	assign interrupt_out_a_oe = st_reg.ia_oe;
	assign interrupt_out_b = st_reg.ib;
	assign interrupt_out_b_oe = st_reg.ib_oe;
	assign rx_loop_data = st_reg.rxl;
	assign loop_active = st_reg.loop;
	assign prescale_div4 = st_reg.pre;
	assign threshold_access = st_reg.thr;
	assign xon_any_en = st_reg.xany;
	assign ready_summary_en = st_reg.rdy;
	assign modem_irq = st_reg.mirq;
	assign irq = st_reg.irq;
endmodule

//--- core/umcs_map.svh
// umcs_map.svh: offsets, field positions, reset values for the modem control/status block
// assumes: included by umcs_top and the verification files, 32-bit apb byte addressing
`ifndef UMCS_MAP_SVH
`define UMCS_MAP_SVH

// ==========================================
// register byte offsets
`define UMCS_OFF_CTRL 12'h000
`define UMCS_OFF_STAT 12'h004
`define UMCS_OFF_CFG 12'h008
`define UMCS_OFF_IRQ_STAT 12'h00C
`define UMCS_OFF_IRQ_CLR 12'h010
`define UMCS_OFF_IRQ_EN 12'h014

// ==========================================
// modem control fields
`define UMCS_CTRL_DTR 0
`define UMCS_CTRL_RTS 1
`define UMCS_CTRL_RDY 2
`define UMCS_CTRL_IRQOP 3
`define UMCS_CTRL_LOOP 4
`define UMCS_CTRL_XANY 5
`define UMCS_CTRL_THR 6
`define UMCS_CTRL_PRE 7

// config fields
`define UMCS_CFG_EWE 0
`define UMCS_CFG_MIE 1
`define UMCS_CFG_ARTS 2

// ==========================================
// reset values
`define UMCS_CTRL_RST 8'h00
`define UMCS_CFG_RST 8'h00
`define UMCS_IRQ_EN_RST 8'h00

`endif

//--- core/umcs_pkg.sv
// umcs_pkg.sv: types shared by the modem control/status block
// assumes: nothing beyond the map header
package umcs_pkg;
	typedef logic [7:0] umcs_byte_t;
	typedef logic [3:0] umcs_nib_t;
endpackage

//--- core/umcs_sync.sv
// umcs_sync.sv: three-stage synchroniser per bit, output changes when stages two and three agree
// assumes: inputs asynchronous to clk
`timescale 1ns/1ps
module umcs_sync
	import umcs_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter logic [3:0] INIT = 4'hF
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} umcs_sync_state_t;

	umcs_sync_state_t st_reg;
	umcs_sync_state_t st_next;

	initial
	begin
		if (WIDTH < 1 || WIDTH > 4)
			$error("umcs_sync width out of range");
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// glitch filter: stage one is read only by stage two
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_reg.s2[i] == st_reg.s3[i])
				st_next.q[i] = st_reg.s3[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_reg.s1 <= INIT[WIDTH-1:0];
			st_reg.s2 <= INIT[WIDTH-1:0];
			st_reg.s3 <= INIT[WIDTH-1:0];
			st_reg.q <= INIT[WIDTH-1:0];
		end
		else
			st_reg <= st_next;
	end

	assign dout = st_reg.q;
endmodule

//--- core/umcs_delta.sv
// umcs_delta.sv: change-indication flags with clear-on-read, set beating clear
// assumes: cur is already synchronous and active-high
`timescale 1ns/1ps
module umcs_delta
	import umcs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] cur,
	input wire logic rd_clr,
	output logic [3:0] delta,
	output logic [3:0] evt
);
	typedef struct packed
	{
		logic [3:0] prev;
		logic [3:0] flag;
		logic prim;
	} umcs_delta_state_t;

	umcs_delta_state_t st_reg;
	umcs_delta_state_t st_next;
	logic [3:0] chg;

	always_comb
	begin
		st_next = st_reg;
		st_next.prev = cur;
		st_next.prim = 1'b1;
		chg = 4'h0;
		// bit order: 3=cd 2=ri 1=dsr 0=cts
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2)
				chg[i] = st_reg.prim & ~cur[i] & st_reg.prev[i];
			else
				chg[i] = st_reg.prim & (cur[i] ^ st_reg.prev[i]);
			if (rd_clr)
				st_next.flag[i] = 1'b0;
			if (chg[i])
				st_next.flag[i] = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_reg.prev <= 4'h0;
			st_reg.flag <= 4'h0;
			st_reg.prim <= 1'b0;
		end
		else
			st_reg <= st_next;
	end

	assign delta = st_reg.flag;
	assign evt = chg;
endmodule

//--- verif/umcs_modem.sv
// umcs_modem.sv: modem partner that drives the active-low status lines
// assumes: bench changes line just after a rising clk edge
`timescale 1ns/1ps
module umcs_modem (
	input wire logic [3:0] line,
	output logic cd_n,
	output logic ri_n,
	output logic dsr_n,
	output logic cts_n
);
	// ====
	// line order cd, ri, dsr, cts; asserted high here, low on the pins
	assign {cd_n, ri_n, dsr_n, cts_n} = ~line;
endmodule

//--- verif/umcs_top_asserts.sv
// umcs_top_asserts.sv: port checks for the modem control/status block
// assumes: bound to umcs_top, apb slave with one wait state
`timescale 1ns/1ps
`include "umcs_map.svh"
module umcs_top_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_serial,
	input wire logic chan_irq_a,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic general_output_pin,
	input wire logic interrupt_out_a,
	input wire logic interrupt_out_a_oe,
	input wire logic rx_loop_data,
	input wire logic loop_active
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ====
	// sequences
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctrl_wr;
		pready && pwrite && pstrb[0] && paddr == `UMCS_OFF_CTRL;
	endsequence
	// ====
	// checks
	AST_ONE_WAIT:
		assert property (s_setup ##1 psel && penable |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	AST_UNMAPPED:
		assert property (pready && paddr > `UMCS_OFF_IRQ_EN |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_RD_UPPER:
		assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_GOP:
		assert property (general_output_pin == (loop_active || !interrupt_out_a_oe))
		else $error("general output does not follow enable");
	AST_IRQ_OUT:
		assert property (interrupt_out_a == (interrupt_out_a_oe && $past(chan_irq_a)))
		else $error("interrupt output not gated by enable");
	AST_LOOP_LINES:
		assert property ($past(loop_active) && loop_active |-> rts_n && dtr_n)
		else $error("modem outputs active in loopback");
	AST_RX_LOOP:
		assert property ($past(rstn) |-> rx_loop_data == $past(tx_serial))
		else $error("transmit not looped to receive");
	AST_CTRL_LOOP:
		assert property (s_ctrl_wr |-> ##2 loop_active == $past(pwdata[4], 2))
		else $error("loopback flag does not follow write");
endmodule
bind umcs_top umcs_top_asserts umcs_top_asserts_inst (.*);

//--- verif/test_uart_modem_control_status.sv
// test_uart_modem_control_status.sv: self-checking bench for umcs_top
// assumes: 40 MHz clk, modem partner umcs_modem, checker bound separately
`timescale 1ns/1ps
`include "umcs_map.svh"
module test_uart_modem_control_status
	import umcs_pkg::*;
;
	typedef struct {umcs_byte_t w; logic [8:0] pins; umcs_nib_t st;} umcs_row_t;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, tx_serial = 0;
	logic chan_irq_a = 0, chan_irq_b = 0, auto_rts_level_n = 1;
	logic [3:0] pstrb = 4'hF, line = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pready, pslverr, cd_n, ri_n, dsr_n, cts_n, rts_n, dtr_n, general_output_pin;
	logic interrupt_out_a, interrupt_out_a_oe, interrupt_out_b, interrupt_out_b_oe;
	logic rx_loop_data, loop_active, prescale_div4, threshold_access, xon_any_en;
	logic ready_summary_en, modem_irq, irq, errv;
	int n_errors = 0, checked = 0;
	wire logic [8:0] pins = {prescale_div4, threshold_access, xon_any_en, loop_active,
		interrupt_out_a_oe, ready_summary_en, rts_n, dtr_n, general_output_pin};
	umcs_row_t rows [6] = '{'{8'h00, 9'h007, 4'h0}, '{8'hE0, 9'h1C7, 4'h0},
		'{8'h0F, 9'h018, 4'h0}, '{8'h1F, 9'h03F, 4'hF}, '{8'h15, 9'h02F, 4'h6},
		'{8'h1A, 9'h037, 4'h9}};

	umcs_top umcs_top_inst (.*);
	umcs_modem umcs_modem_inst (.*);

	always #12.5 clk = ~clk;
	always @(posedge clk) tx_serial <= ~tx_serial;

	// ====
	// bus and compare tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chkp(input string s, input logic [8:0] e);
		chk(s, {23'h0, e}, {23'h0, pins});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string s);
		apb(1'h0, a, 32'h0);
		chk(s, e, rdv);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		complete_run;
	end

	// ====
	// main sequence; six-cycle waits cover synchroniser and edge detector
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		chkp("reset pins", 9'h007);
		rd(`UMCS_OFF_CTRL, 32'h0, "ctrl");
		rd(`UMCS_OFF_STAT, 32'h0, "status");
		rd(`UMCS_OFF_CFG, 32'h0, "cfg");
		rd(`UMCS_OFF_IRQ_EN, 32'h0, "irq enable");
		apb(1'h1, `UMCS_OFF_CTRL, 32'hFF);
		rd(`UMCS_OFF_CTRL, 32'h1F, "ctrl locked");
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, errv});
		$display("test reset done");
		apb(1'h1, `UMCS_OFF_CFG, 32'h03);
		chan_irq_a <= 1'h1;
		chan_irq_b <= 1'h1;
		foreach (rows[i])
		begin
			apb(1'h1, `UMCS_OFF_CTRL, {24'h0, rows[i].w});
			repeat (6) @(posedge clk);
			chkp("pins", rows[i].pins);
			rd(`UMCS_OFF_CTRL, {24'h0, rows[i].w}, "ctrl");
			apb(1'h0, `UMCS_OFF_STAT, 32'h0);
			chk("status high", {28'h0, rows[i].st}, {28'h0, rdv[7:4]});
		end
		apb(1'h1, `UMCS_OFF_CTRL, 32'h0);
		repeat (6) @(posedge clk);
		apb(1'h0, `UMCS_OFF_STAT, 32'h0);
		apb(1'h1, `UMCS_OFF_IRQ_CLR, 32'h0F);
		$display("test table done");
		line <= 4'h8;
		repeat (6) @(posedge clk);
		chk("modem irq", 32'h1, {31'h0, modem_irq});
		rd(`UMCS_OFF_STAT, 32'h88, "status cd");
		rd(`UMCS_OFF_STAT, 32'h80, "status cleared");
		chk("modem irq", 32'h0, {31'h0, modem_irq});
		line <= 4'hC;
		repeat (6) @(posedge clk);
		rd(`UMCS_OFF_STAT, 32'hC0, "status ri fall");
		line <= 4'h8;
		repeat (6) @(posedge clk);
		rd(`UMCS_OFF_STAT, 32'h84, "status ri rise");
		line <= 4'hB;
		repeat (6) @(posedge clk);
		rd(`UMCS_OFF_STAT, 32'hB3, "status dsr cts");
		apb(1'h1, `UMCS_OFF_CFG, 32'h01);
		line <= 4'h0;
		repeat (6) @(posedge clk);
		chk("modem irq masked", 32'h0, {31'h0, modem_irq});
		rd(`UMCS_OFF_STAT, 32'h0B, "status release");
		$display("test modem lines done");
		rd(`UMCS_OFF_IRQ_STAT, 32'h0F, "irq status");
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'h1, `UMCS_OFF_IRQ_EN, 32'h0F);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'h1, `UMCS_OFF_IRQ_CLR, 32'h0F);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(`UMCS_OFF_IRQ_STAT, 32'h0, "irq status cleared");
		$display("test irq done");
		apb(1'h1, `UMCS_OFF_CTRL, 32'h08);
		chk("irq out b", 32'h3, {30'h0, interrupt_out_b, interrupt_out_b_oe});
		apb(1'h1, `UMCS_OFF_CFG, 32'h04);
		auto_rts_level_n <= 1'h0;
		repeat (2) @(posedge clk);
		chk("auto rts low", 32'h0, {31'h0, rts_n});
		auto_rts_level_n <= 1'h1;
		repeat (2) @(posedge clk);
		chk("auto rts high", 32'h1, {31'h0, rts_n});
		$display("test outputs done");
		complete_run;
	end
endmodule
